// ### logic/dfpc_top.sv
/*
  two-channel film phase sequencer: mode select, film phases, shutters,
  indicators, thickness accumulation and rate sampling.
  assumes config inputs are static logic on ref_clk; buttons, remote
  inputs and crystal fail flags are asynchronous pins.
*/
`timescale 1ns/100ps
module dfpc_top
  import dfpc_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire dfpc_mode_t  cfg_mode,
  input  wire logic        cfg_test,
  input  wire logic        cfg_phase_a,
  input  wire logic [1:0]  cfg_sd_en,
  input  wire logic [1:0]  cfg_samp_en,
  input  wire logic [6:0]  cfg_weight,
  input  wire logic [31:0] cfg_end_thk1,
  input  wire logic [31:0] cfg_end_thk2,
  input  wire logic [31:0] cfg_stpt_thk1,
  input  wire logic [31:0] cfg_stpt_thk2,
  input  wire logic [15:0] cfg_stpt_ms1,
  input  wire logic [15:0] cfg_stpt_ms2,
  input  wire logic [15:0] cfg_dep_rate1,
  input  wire logic [15:0] cfg_dep_rate2,
  input  wire logic [15:0] cfg_samp_ms1,
  input  wire logic [15:0] cfg_samp_ms2,
  input  wire logic [15:0] cfg_hold_ms1,
  input  wire logic [15:0] cfg_hold_ms2,
  input  wire logic [15:0] sens1_rate,
  input  wire logic [15:0] sens2_rate,
  input  wire logic [1:0]  open_btn,
  input  wire logic [1:0]  close_btn,
  input  wire logic [1:0]  sel_btn,
  input  wire logic [1:0]  zero_btn,
  input  wire logic [1:0]  rmt_zero,
  input  wire logic [1:0]  xtal_fail,
  output wire logic [1:0]  src_shutter,
  output wire logic [1:0]  subs_shutter,
  output wire logic [1:0]  sens_shutter,
  output wire logic [1:0]  open_led,
  output wire logic [1:0]  rate_blink,
  output wire logic [1:0]  ind_time,
  output wire logic [1:0]  ind_thk,
  output wire logic [1:0]  ind_end,
  output wire logic        active_sensor,
  output wire dfpc_phase_t phase1,
  output wire dfpc_phase_t phase2,
  output wire logic [31:0] thick1,
  output wire logic [31:0] thick2,
  output wire logic [15:0] rate1,
  output wire logic [15:0] rate2,
  output wire logic [15:0] ratio
);
  typedef struct packed {
    dfpc_mode_t              mode;
    dfpc_phase_t [1:0]       phase;
    logic                    act_sens;
    logic [PIN_W-1:0]        pin_prev;
    logic [1:0][31:0]        thick;
    logic [1:0][15:0]        rate;
    logic [1:0][15:0]        elapsed;
    logic [1:0]              ind_time;
    logic [1:0]              ind_thk;
    logic [1:0]              ind_end;
    logic [1:0]              src;
    logic [1:0]              subs;
    logic [1:0]              sens;
    logic [1:0]              open_led;
    logic [1:0]              rate_blink;
    logic [15:0]             ratio;
    logic [14:0]             ms_cnt;
    logic                    ms_tick;
    logic [15:0]             blink_cnt;
    logic                    blink;
  } dfpc_state_t;

  dfpc_state_t      st_q;
  dfpc_state_t      st_d;
  logic [PIN_W-1:0] pin_s;
  logic [PIN_W-1:0] pin_ev;
  logic [1:0][15:0] s_rate;
  logic [1:0][15:0] live;
  logic [1:0][15:0] gate;
  logic [1:0]       xf;
  logic [1:0]       fail;
  logic [1:0]       open_eff;
  logic [1:0]       close_eff;
  logic [1:0]       zero_eff;
  logic [1:0]       chan_on;
  logic [1:0]       tmr_load;
  logic [1:0][15:0] tmr_val;
  logic [1:0]       tmr_done;
  logic [1:0][31:0] end_thk;
  logic [1:0][31:0] stpt_thk;
  logic [1:0][15:0] stpt_ms;
  logic [1:0][15:0] dep_rate;
  logic [1:0][15:0] samp_ms;
  logic [1:0][15:0] hold_ms;
  logic [1:0][31:0] thick_n;
  logic [6:0]       w_eff;
  logic [23:0]      avg_sum;
  logic             split;

  assign end_thk  = {cfg_end_thk2, cfg_end_thk1};
  assign stpt_thk = {cfg_stpt_thk2, cfg_stpt_thk1};
  assign stpt_ms  = {cfg_stpt_ms2, cfg_stpt_ms1};
  assign dep_rate = {cfg_dep_rate2, cfg_dep_rate1};
  assign samp_ms  = {cfg_samp_ms2, cfg_samp_ms1};
  assign hold_ms  = {cfg_hold_ms2, cfg_hold_ms1};

  dfpc_sync #(
    .W (PIN_W)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin_in  ({xtal_fail, rmt_zero, zero_btn, sel_btn, close_btn,
               open_btn}),
    .pin_out (pin_s)
  );

  genvar gc;
  generate
    for (gc = 0; gc < 2; gc++) begin : g_tmr
      dfpc_tmr u_tmr (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .tick     (st_q.ms_tick),
        .load     (tmr_load[gc]),
        .load_val (tmr_val[gc]),
        .done     (tmr_done[gc])
      );
    end
  endgenerate

  // sensor selection, weighting and failure per channel
  always_comb begin
    pin_ev  = pin_s & ~st_q.pin_prev;
    split   = (st_q.mode == MODE_ALLOY) || (st_q.mode == MODE_INDEP);
    chan_on = {split, 1'b1};
    s_rate[0] = cfg_test ? TEST_RATE : sens1_rate;
    s_rate[1] = cfg_test ? TEST_RATE : sens2_rate;
    // simulated sensors never fail
    xf = cfg_test ? 2'b00 : pin_s[11:10];
    w_eff = ((cfg_weight == 7'h00) || (cfg_weight > PCT_FULL))
            ? AVG_WEIGHT_DEF : cfg_weight;
    avg_sum = 24'(w_eff) * 24'(s_rate[0])
              + 24'(PCT_FULL - w_eff) * 24'(s_rate[1]);
    // sensor 2 bound to channel 2
    live[1] = s_rate[1];
    fail[1] = xf[1];
    case (st_q.mode)
      MODE_SIMPLE: begin
        live[0] = s_rate[0];
        fail[0] = xf[0];
      end
      // fails only when both sensors are gone
      MODE_BACKUP: begin
        live[0] = st_q.act_sens ? s_rate[1] : s_rate[0];
        fail[0] = xf[0] & xf[1];
      end
      // averaging needs both sensors working
      MODE_AVG: begin
        live[0] = 16'(avg_sum / 24'(PCT_FULL));
        fail[0] = xf[0] | xf[1];
      end
      default: begin
        live[0] = s_rate[0];
        fail[0] = xf[0];
      end
    endcase
    // alloy links both channels to either button
    if (st_q.mode == MODE_ALLOY) begin
      open_eff  = {2{pin_ev[0] | pin_ev[1]}};
      close_eff = {2{pin_ev[2] | pin_ev[3]}};
    end else begin
      open_eff  = pin_ev[1:0];
      close_eff = pin_ev[3:2];
    end
    // remote zero same as panel zero
    zero_eff = pin_ev[7:6] | pin_ev[9:8];
    for (int c = 0; c < 2; c++) begin
      // hold gate is max of half rate and floor
      gate[c] = ((dep_rate[c] >> 1) > RATE_FLOOR) ? (dep_rate[c] >> 1)
                                                  : RATE_FLOOR;
    end
  end

  always_comb begin
    dfpc_phase_t ph;
    dfpc_phase_t nph;
    logic [1:0]  sens_ch;
    logic        acc;
    ph       = PH_READY;
    nph      = PH_READY;
    sens_ch  = 2'b11;
    acc      = 1'b0;
    st_d     = st_q;
    tmr_load = 2'b00;
    tmr_val  = '0;
    thick_n  = st_q.thick;
    st_d.pin_prev = pin_s;
    st_d.ms_tick  = 1'b0;
    if (st_q.ms_cnt == 15'(MS_CYCLES - 1)) begin
      st_d.ms_cnt  = '0;
      st_d.ms_tick = 1'b1;
    end else begin
      st_d.ms_cnt = st_q.ms_cnt + 15'h0001;
    end
    if (st_q.ms_tick) begin
      if (st_q.blink_cnt == BLINK_MS - 16'h0001) begin
        st_d.blink_cnt = '0;
        st_d.blink     = ~st_q.blink;
      end else begin
        st_d.blink_cnt = st_q.blink_cnt + 16'h0001;
      end
    end
    // mode taken only with both films idle
    if (st_q.phase[0] == PH_READY && st_q.phase[1] == PH_READY) begin
      st_d.mode = cfg_mode;
    end
    if (st_q.mode == MODE_BACKUP) begin
      if (pin_ev[4]) begin
        st_d.act_sens = 1'b0;
      end else if (pin_ev[5]) begin
        st_d.act_sens = 1'b1;
      // automatic switch to the healthy sensor
      end else if (xf[st_q.act_sens] && !xf[~st_q.act_sens]) begin
        st_d.act_sens = ~st_q.act_sens;
      end
    end
    // ratio follows the present rates only
    if (st_q.mode == MODE_ALLOY) begin
      st_d.ratio = (live[1] == 16'h0000) ? RATIO_DIV0
                 : 16'((24'(live[0]) * RATIO_SCALE) / 24'(live[1]));
    end else begin
      st_d.ratio = 16'h0000;
    end
    for (int c = 0; c < 2; c++) begin
      ph  = st_q.phase[c];
      nph = ph;
      acc = (ph == PH_DEPOSIT) || (ph == PH_HOLD) || (ph == PH_SETTLE)
            || (ph == PH_A);
      // thickness grows at the held rate, also while coasting
      if (acc && st_q.ms_tick) begin
        thick_n[c] = st_q.thick[c] + 32'(st_q.rate[c]);
        st_d.elapsed[c] = st_q.elapsed[c] + 16'h0001;
      end
      if (zero_eff[c]) begin
        thick_n[c] = THICK_RST;
      end
      st_d.thick[c] = thick_n[c];
      if (ph == PH_READY || ph == PH_SHUT_DELAY || ph == PH_DEPOSIT) begin
        st_d.rate[c] = live[c];
      end
      case (ph)
        PH_READY: begin
          if (open_eff[c]) begin
            st_d.ind_time[c] = 1'b0;
            st_d.ind_thk[c]  = 1'b0;
            st_d.ind_end[c]  = 1'b0;
            st_d.elapsed[c]  = 16'h0000;
            nph = cfg_sd_en[c] ? PH_SHUT_DELAY : PH_DEPOSIT;
            tmr_load[c] = !cfg_sd_en[c];
            tmr_val[c]  = samp_ms[c];
          end
        end
        PH_SHUT_DELAY: begin
          if (close_eff[c]) begin
            nph = PH_READY;
          end else if (fail[c]) begin
            nph = PH_XFAIL;
          end else if (open_eff[c]) begin
            nph = PH_DEPOSIT;
            tmr_load[c] = 1'b1;
            tmr_val[c]  = samp_ms[c];
          end
        end
        PH_DEPOSIT, PH_HOLD, PH_SETTLE: begin
          if (close_eff[c]) begin
            nph = PH_READY;
          end else if (thick_n[c] >= end_thk[c]) begin
            nph = PH_READY;
            st_d.ind_end[c] = 1'b1;
          // phase_a or abort on crystal failure
          end else if (fail[c]) begin
            nph = cfg_phase_a ? PH_A : PH_XFAIL;
          end else if (ph == PH_DEPOSIT) begin
            if (cfg_samp_en[c] && tmr_done[c]) begin
              tmr_load[c] = 1'b1;
              // too low a rate keeps sampling
              if (st_q.rate[c] >= gate[c]) begin
                nph        = PH_HOLD;
                tmr_val[c] = hold_ms[c];
              end else begin
                tmr_val[c] = samp_ms[c];
              end
            end
          end else if (tmr_done[c]) begin
            nph = (ph == PH_HOLD) ? PH_SETTLE : PH_DEPOSIT;
            tmr_load[c] = 1'b1;
            tmr_val[c]  = (ph == PH_HOLD) ? SETTLE_MS : samp_ms[c];
          end
        end
        PH_A: begin
          if (close_eff[c]) begin
            nph = PH_READY;
          end else if (thick_n[c] >= end_thk[c]) begin
            nph = PH_DONE_FAIL;
            st_d.ind_end[c] = 1'b1;
          end
        end
        PH_DONE_FAIL, PH_XFAIL: begin
          if (!fail[c]) begin
            nph = PH_READY;
          end
        end
        default: nph = PH_READY;
      endcase
      if (!chan_on[c]) begin
        nph = PH_READY;
      end
      if (acc && thick_n[c] >= stpt_thk[c]) begin
        st_d.ind_thk[c] = 1'b1;
      end
      if (acc && st_d.elapsed[c] >= stpt_ms[c]) begin
        st_d.ind_time[c] = 1'b1;
      end
      if (st_q.mode == MODE_INDEP) begin
        st_d.ind_time[c] = 1'b0;
        st_d.ind_thk[c]  = 1'b0;
      end
      st_d.phase[c] = nph;
      st_d.src[c]  = (nph == PH_SHUT_DELAY) || (nph == PH_DEPOSIT)
                     || (nph == PH_HOLD) || (nph == PH_SETTLE)
                     || (nph == PH_A);
      st_d.subs[c] = (nph == PH_DEPOSIT) || (nph == PH_HOLD)
                     || (nph == PH_SETTLE) || (nph == PH_A);
      sens_ch[c]   = !((nph == PH_HOLD) || (nph == PH_XFAIL));
      // blinking open lamp in shutter delay
      st_d.open_led[c]   = (nph == PH_SHUT_DELAY) ? st_d.blink
                                                  : st_d.src[c];
      st_d.rate_blink[c] = (nph == PH_HOLD) && st_d.blink;
    end
    // one channel drives both sensor shutters unless split
    st_d.sens = split ? sens_ch : {2{sens_ch[0]}};
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q          <= '0;
      st_q.mode     <= MODE_SIMPLE;
      st_q.phase    <= {PH_READY, PH_READY};
      st_q.sens     <= 2'b11;
      st_q.thick    <= {THICK_RST, THICK_RST};
      st_q.rate     <= {RATE_RST, RATE_RST};
    end else begin
      st_q <= st_d;
    end
  end

  assign src_shutter   = st_q.src;
  assign subs_shutter  = st_q.subs;
  assign sens_shutter  = st_q.sens;
  assign open_led      = st_q.open_led;
  assign rate_blink    = st_q.rate_blink;
  assign ind_time      = st_q.ind_time;
  assign ind_thk       = st_q.ind_thk;
  assign ind_end       = st_q.ind_end;
  assign active_sensor = st_q.act_sens;
  assign phase1        = st_q.phase[0];
  assign phase2        = st_q.phase[1];
  assign thick1        = st_q.thick[0];
  assign thick2        = st_q.thick[1];
  assign rate1         = st_q.rate[0];
  assign rate2         = st_q.rate[1];
  assign ratio         = st_q.ratio;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_rdy_open;
    st_q.phase[0] == PH_READY && open_eff[0] && !cfg_sd_en[0]
    && !close_eff[0] && chan_on[0];
  endsequence

  sequence s_dep_clear;
    st_q.phase[0] == PH_DEPOSIT && !st_q.ind_end[0]
    && !(st_q.ind_thk[0] && thick_n[0] < stpt_thk[0]);
  endsequence

  a_open_deposit: assert property (s_rdy_open |=> s_dep_clear)
    else $error("open in ready did not start a clean deposit");
  a_end_close: assert property (st_q.phase[0] == PH_DEPOSIT && !fail[0]
    && !close_eff[0] && thick_n[0] >= end_thk[0] |=> !st_q.src[0]
    && st_q.phase[0] == PH_READY && st_q.ind_end[0])
    else $error("end thickness did not close source");
  a_zero_sum: assert property (zero_eff[0] |=> st_q.thick[0] == '0)
    else $error("zero did not clear thickness");
  a_delay_shut: assert property (st_q.phase[0] == PH_SHUT_DELAY
    |-> st_q.src[0] && !st_q.subs[0])
    else $error("shutter delay shutters wrong");
  a_hold_gate: assert property (st_q.phase[0] == PH_DEPOSIT
    ##1 st_q.phase[0] == PH_HOLD
    |-> $past(st_q.rate[0]) >= $past(gate[0]))
    else $error("hold entered below rate gate");
  a_hold_rate: assert property (st_q.phase[0] == PH_HOLD [*2]
    |-> $stable(st_q.rate[0]) && !st_q.sens[0])
    else $error("rate not held in hold");
  a_phase_a_done: assert property (st_q.phase[0] == PH_A && !close_eff[0]
    && thick_n[0] >= end_thk[0] |=> st_q.phase[0] == PH_DONE_FAIL)
    else $error("phase_a did not complete at end");
  a_xfail_shut: assert property (st_q.phase[0] == PH_XFAIL
    |-> !st_q.src[0] && !st_q.subs[0] && !st_q.sens[0])
    else $error("shutter open in aborted failure");
  a_ready_shut: assert property (st_q.phase[0] == PH_READY
    |-> !st_q.src[0] && !st_q.subs[0] && st_q.sens[0])
    else $error("ready shutters wrong");
  a_dep_open: assert property (st_q.phase[0] == PH_DEPOSIT
    |-> st_q.src[0] && st_q.subs[0] && st_q.sens[0])
    else $error("deposit shutters not all open");
  a_indep_ind: assert property (st_q.mode == MODE_INDEP
    |=> st_q.ind_time == 2'b00 && st_q.ind_thk == 2'b00)
    else $error("setpoint indicator on in independent mode");
  a_mode_static: assert property (st_q.phase[0] != PH_READY
    || st_q.phase[1] != PH_READY |=> $stable(st_q.mode))
    else $error("mode changed during a film");
endmodule

// ### include/dfpc_pkg.sv
/*
  constants, modes and film phases of the film phase controller.
  assumes one 20 mhz clock; rates in 0.1 A/s, times in ms.
*/
package dfpc_pkg;

  typedef enum logic [7:0] {
    PH_READY      = 8'h01,
    PH_SHUT_DELAY = 8'h02,
    PH_DEPOSIT    = 8'h04,
    PH_HOLD       = 8'h08,
    PH_SETTLE     = 8'h10,
    PH_A          = 8'h20,
    PH_DONE_FAIL  = 8'h40,
    PH_XFAIL      = 8'h80
  } dfpc_phase_t;

  typedef enum logic [2:0] {
    MODE_SIMPLE = 3'h0,
    MODE_BACKUP = 3'h1,
    MODE_AVG    = 3'h2,
    MODE_ALLOY  = 3'h3,
    MODE_INDEP  = 3'h4
  } dfpc_mode_t;

  localparam int          CLK_PERIOD_NS  = 50;
  localparam int          MS_PERIOD_NS   = 1000000;
  localparam int          MS_CYCLES_DEF  = (MS_PERIOD_NS + CLK_PERIOD_NS - 1)
                                           / CLK_PERIOD_NS;
  localparam logic [15:0] BLINK_MS       = 16'h00fa;
  localparam logic [15:0] SETTLE_MS      = 16'h01f4;
  localparam logic [6:0]  AVG_WEIGHT_DEF = 7'h32;
  localparam logic [6:0]  PCT_FULL       = 7'h64;
  localparam logic [15:0] RATE_FLOOR     = 16'h0005;
  localparam logic [15:0] TEST_RATE      = 16'h0014;
  localparam logic [23:0] RATIO_SCALE    = 24'h000064;
  localparam logic [15:0] RATIO_DIV0     = 16'hffff;
  localparam logic [31:0] THICK_RST      = 32'h00000000;
  localparam logic [15:0] RATE_RST       = 16'h0000;
  localparam int          PIN_W          = 12;

endpackage

// ### logic/dfpc_sync.sv
/*
  two flip-flop synchroniser for a vector of pin levels.
  assumes each bit is an independent slow level from outside.
*/
`timescale 1ns/100ps
module dfpc_sync #(
  parameter int W = 12
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin_in,
  output wire logic [W-1:0] pin_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dfpc_sync_t;

  dfpc_sync_t st_q;
  dfpc_sync_t st_d;

  // first stage feeds only the second stage
  always_comb begin
    st_d    = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pin_out = st_q.s2;
endmodule

// ### logic/dfpc_tmr.sv
/*
  millisecond down-counter for sample, hold and settle intervals.
  assumes tick is a one-cycle pulse each ms from the same clock.
*/
`timescale 1ns/100ps
module dfpc_tmr (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        tick,
  input  wire logic        load,
  input  wire logic [15:0] load_val,
  output wire logic        done
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        run;
    logic        done;
  } dfpc_tmr_t;

  dfpc_tmr_t st_q;
  dfpc_tmr_t st_d;

  always_comb begin
    st_d      = st_q;
    st_d.done = 1'b0;
    if (load) begin
      st_d.cnt = load_val;
      st_d.run = 1'b1;
    end else if (tick && st_q.run) begin
      // zero load expires on the first tick
      if (st_q.cnt <= 16'h0001) begin
        st_d.run  = 1'b0;
        st_d.done = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign done = st_q.done;
endmodule

// ### testbench/dfpc_far.sv
/*
  far-side model: two quartz sensors seen through their shutters.
  assumes the bench sets source rate and crystal failure levels.
*/
`timescale 1ns/100ps
module dfpc_far (
  input  wire logic [0:0]  ref_clk,
  input  wire logic [1:0]  sens_shutter,
  input  wire logic [15:0] rate_set,
  input  wire logic [1:0]  fail_set,
  output var  logic [15:0] sens1_rate,
  output var  logic [15:0] sens2_rate,
  output var  logic [1:0]  xtal_fail
);
  // a shuttered crystal sees no flux, so it reads zero; the second
  // crystal sits nearer the source and reads twice the flux
  always @(negedge ref_clk) begin
    sens1_rate <= sens_shutter[0] ? rate_set : 16'h0000;
    sens2_rate <= sens_shutter[1] ? {rate_set[14:0], 1'b0} : 16'h0000;
    xtal_fail  <= fail_set;
  end
endmodule

// ### testbench/tb_top.sv
/*
  self-checking bench for the film phase controller.
  assumes MS_CYCLES of 20 so that a ms is 20 clocks.
*/
`timescale 1ns/100ps
module tb_top;
  import dfpc_pkg::*;
  logic        ref_clk, rst, cfg_test, cfg_phase_a, active_sensor;
  dfpc_mode_t  cfg_mode;
  dfpc_phase_t phase1, phase2;
  logic [1:0]  cfg_sd_en, cfg_samp_en, open_btn, close_btn, sel_btn;
  logic [1:0]  zero_btn, rmt_zero, xtal_fail, fail_set, src_shutter;
  logic [1:0]  subs_shutter, sens_shutter, open_led, rate_blink;
  logic [1:0]  ind_time, ind_thk, ind_end;
  logic [6:0]  cfg_weight;
  logic [31:0] cfg_end_thk1, cfg_end_thk2, cfg_stpt_thk1, cfg_stpt_thk2;
  logic [31:0] thick1, thick2;
  logic [15:0] cfg_stpt_ms1, cfg_stpt_ms2, cfg_dep_rate1, cfg_dep_rate2;
  logic [15:0] cfg_samp_ms1, cfg_samp_ms2, cfg_hold_ms1, cfg_hold_ms2;
  logic [15:0] sens1_rate, sens2_rate, rate1, rate2, ratio, rate_set;
  int          n_fail, checked, cyc;

  dfpc_top #(.MS_CYCLES(20)) dut_u (
    .ref_clk, .rst, .cfg_mode, .cfg_test, .cfg_phase_a, .cfg_sd_en,
    .cfg_samp_en, .cfg_weight, .cfg_end_thk1, .cfg_end_thk2,
    .cfg_stpt_thk1, .cfg_stpt_thk2, .cfg_stpt_ms1, .cfg_stpt_ms2,
    .cfg_dep_rate1, .cfg_dep_rate2, .cfg_samp_ms1, .cfg_samp_ms2,
    .cfg_hold_ms1, .cfg_hold_ms2, .sens1_rate, .sens2_rate, .open_btn,
    .close_btn, .sel_btn, .zero_btn, .rmt_zero, .xtal_fail, .src_shutter,
    .subs_shutter, .sens_shutter, .open_led, .rate_blink, .ind_time,
    .ind_thk, .ind_end, .active_sensor, .phase1, .phase2, .thick1,
    .thick2, .rate1, .rate2, .ratio);
  dfpc_far far_u (.ref_clk, .sens_shutter, .rate_set, .fail_set,
    .sens1_rate, .sens2_rate, .xtal_fail);

  task automatic finish_test();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk_ph(dfpc_phase_t g, dfpc_phase_t e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t phase %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_v(logic [31:0] g, logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t value %h exp %h", $time, g, e);
    end
  endtask
  // press then release; sync plus edge detect needs three clocks
  task automatic press(int k, logic [1:0] m);
    @(negedge ref_clk);
    case (k)
      0: open_btn = m;
      1: close_btn = m;
      2: sel_btn = m;
      3: zero_btn = m;
      default: rmt_zero = m;
    endcase
    repeat (2) @(negedge ref_clk);
    {open_btn, close_btn, sel_btn, zero_btn, rmt_zero} = 10'h000;
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic wait_ph(dfpc_phase_t e, int n);
    for (int i = 0; i < n && phase1 !== e; i++) @(negedge ref_clk);
    chk_ph(phase1, e);
  endtask
  task automatic t_plain();
    press(0, 2'h1);
    chk_ph(phase1, PH_DEPOSIT);
    chk_v(32'({src_shutter[0], subs_shutter[0], sens_shutter[0]}), 32'h7);
    chk_v(32'({open_led[0], rate_blink[0]}), 32'h2);
    chk_v(32'(rate1), 32'ha);
    wait_ph(PH_READY, 400);
    chk_v(thick1, 32'h32);
    chk_v(32'({src_shutter[0], ind_end[0]}), 32'h1);
    chk_v(32'({ind_time[0], ind_thk[0]}), 32'h3);
    rate_set = 16'h0000;
    cfg_end_thk1 = 32'h64;
    press(0, 2'h1);
    chk_v(thick1, 32'h32);
    chk_v(32'({ind_time[0], ind_end[0]}), 32'h0);
    press(1, 2'h1);
    press(4, 2'h1);
    chk_v(thick1, 32'h0);
    rate_set = 16'h000a;
  endtask
  task automatic t_delay();
    logic b;
    cfg_sd_en = 2'h1;
    press(0, 2'h1);
    chk_ph(phase1, PH_SHUT_DELAY);
    chk_v(32'({src_shutter[0], subs_shutter[0]}), 32'h2);
    // lamp half period is 250 ms, so wait out one toggle
    b = open_led[0];
    for (int i = 0; i < 5100 && open_led[0] === b; i++) @(negedge ref_clk);
    chk_v(32'(open_led[0]), 32'(!b));
    press(0, 2'h1);
    chk_ph(phase1, PH_DEPOSIT);
    chk_v(32'(subs_shutter[0]), 32'h1);
    press(1, 2'h1);
    cfg_sd_en = 2'h0;
  endtask
  task automatic t_fail();
    press(0, 2'h1);
    fail_set = 2'h1;
    wait_ph(PH_XFAIL, 10);
    chk_v(32'({src_shutter[0], subs_shutter[0], sens_shutter[0]}), 32'h0);
    fail_set = 2'h0;
    wait_ph(PH_READY, 10);
    press(3, 2'h1);
    chk_v(thick1, 32'h0);
    cfg_phase_a = 1'b1;
    press(0, 2'h1);
    fail_set = 2'h1;
    wait_ph(PH_A, 10);
    chk_v(32'({src_shutter[0], subs_shutter[0]}), 32'h3);
    wait_ph(PH_DONE_FAIL, 600);
    chk_v(thick1, 32'h64);
    fail_set = 2'h0;
    wait_ph(PH_READY, 10);
  endtask
  task automatic t_samp();
    cfg_samp_en = 2'h1;
    cfg_end_thk1 = 32'h00010000;
    cfg_dep_rate1 = 16'h0016;
    press(0, 2'h1);
    repeat (200) @(negedge ref_clk);
    chk_ph(phase1, PH_DEPOSIT);
    cfg_dep_rate1 = 16'h0014;
    wait_ph(PH_HOLD, 200);
    chk_v(32'(sens_shutter[0]), 32'h0);
    chk_v(32'(rate1), 32'ha);
    wait_ph(PH_SETTLE, 100);
    chk_v(32'(sens_shutter[0]), 32'h1);
    press(1, 2'h1);
    cfg_samp_en = 2'h0;
  endtask
  task automatic t_modes();
    cfg_mode = MODE_BACKUP;
    repeat (2) @(negedge ref_clk);
    press(2, 2'h2);
    chk_v(32'(active_sensor), 32'h1);
    press(2, 2'h1);
    chk_v(32'(active_sensor), 32'h0);
    fail_set = 2'h1;
    repeat (6) @(negedge ref_clk);
    chk_v(32'(active_sensor), 32'h1);
    fail_set = 2'h0;
    // sensor 2 reads 20, sensor 1 reads 10
    cfg_mode = MODE_AVG;
    repeat (3) @(negedge ref_clk);
    chk_v(32'(rate1), 32'hf);
    cfg_weight = 7'h5a;
    repeat (3) @(negedge ref_clk);
    chk_v(32'(rate1), 32'hb);
    cfg_test = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk_v(32'(rate1), 32'(TEST_RATE));
    cfg_test = 1'b0;
    cfg_mode = MODE_ALLOY;
    cfg_sd_en = 2'h3;
    repeat (2) @(negedge ref_clk);
    press(0, 2'h1);
    chk_v(32'({phase1, phase2}), 32'h0202);
    press(0, 2'h2);
    chk_v(32'({phase1, phase2}), 32'h0404);
    chk_v(32'(ratio), 32'h32);
    repeat (60) @(negedge ref_clk);
    chk_ph(phase2, PH_READY);
    chk_v(thick2, 32'h28);
    press(1, 2'h1);
    cfg_mode = MODE_INDEP;
    cfg_sd_en = 2'h0;
    repeat (2) @(negedge ref_clk);
    press(3, 2'h2);
    chk_v(thick2, 32'h0);
    press(0, 2'h2);
    chk_v(32'({phase1, phase2}), 32'h0104);
    press(1, 2'h2);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // hang guard sized well above the longest scenario
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  initial begin
    {rst, cfg_test, cfg_phase_a, cfg_sd_en, cfg_samp_en} = 7'h40;
    {open_btn, close_btn, sel_btn, zero_btn, rmt_zero} = 10'h000;
    cfg_mode = MODE_SIMPLE;
    {cfg_weight, fail_set} = {7'h32, 2'h0};
    {cfg_end_thk1, cfg_end_thk2} = {32'h32, 32'h28};
    {cfg_stpt_thk1, cfg_stpt_thk2} = {32'h28, 32'hff};
    {cfg_stpt_ms1, cfg_stpt_ms2} = {16'h0003, 16'h00ff};
    {cfg_dep_rate1, cfg_dep_rate2, rate_set} = {32'h0, 16'h000a};
    {cfg_samp_ms1, cfg_samp_ms2} = {16'h0002, 16'h0002};
    {cfg_hold_ms1, cfg_hold_ms2} = {16'h0002, 16'h0002};
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk_ph(phase1, PH_READY);
    chk_v(32'({src_shutter, subs_shutter, sens_shutter}), 32'h3);
    t_plain();
    t_delay();
    t_fail();
    t_samp();
    t_modes();
    finish_test();
  end
endmodule
